// ==== bench/core_irq_partner.sv ====
// Core interrupt source and delivery tally
`timescale 1ns/1ps
module core_irq_partner (
  input  wire logic       sys_clk_i,
  input  wire logic       active_i,
  output logic      [7:0] irq_req_o,
  input  wire logic [7:0] irq_deliver_i,
  output int              raised_o,
  output int              taken_o,
  output logic      [7:0] pending_o,
  output int              stray_o
);
  logic [7:0] pick;
  initial begin
    irq_req_o = 8'h00;
    pending_o = 8'h00;
    raised_o = 0;
    taken_o = 0;
    stray_o = 0;
  end
  // Only idle bits are requested, so a merge in the design never hides a loss
  always @(negedge sys_clk_i) begin
    pick = 8'h01 << $urandom_range(7);
    irq_req_o <= (active_i && !(pending_o & pick) && $urandom_range(1)) ? pick : 8'h00;
  end
  always @(posedge sys_clk_i) begin
    raised_o <= raised_o + $countones(irq_req_o);
    taken_o <= taken_o + $countones(irq_deliver_i);
    stray_o <= stray_o + $countones(irq_deliver_i & ~pending_o);
    pending_o <= (pending_o | irq_req_o) & ~irq_deliver_i;
  end
endmodule

// ==== bench/thermal_clock_throttle_assertions.sv ====
// Port-level assertions for the thermal throttle
`timescale 1ns/1ps
module thermal_clock_throttle_checker
  import thermal_clock_throttle_pkg::*;
#(
  parameter int HOLD_CYCLES = 40
) (
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire logic        catastrophic_trip_i,
  input wire logic        monitor_trip_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_ack_o,
  input wire logic        reg_err_o,
  input wire logic        core_clk_en_o,
  input wire logic        exec_halt_o,
  input wire logic [7:0]  irq_deliver_o,
  input wire logic        therm_irq_o,
  input wire logic [63:0] time_stamp_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_strobe;
    reg_rd_i || reg_wr_i;
  endsequence
  sequence s_halted;
    !core_clk_en_o ##1 exec_halt_o;
  endsequence
  a_ack_follows: assert property (s_strobe |=> reg_ack_o)
    else $error("ack missing after access");
  a_ack_quiet: assert property (!(reg_rd_i || reg_wr_i) |=> !reg_ack_o)
    else $error("ack without access");
  a_err_unmapped: assert property ((reg_rd_i || reg_wr_i) && reg_addr_i > 4'h5 |=> reg_err_o)
    else $error("no error on unmapped index");
  a_halt_on_trip: assert property ($rose(catastrophic_trip_i) |-> ##[1:6] exec_halt_o)
    else $error("catastrophic trip did not halt");
  a_halt_sticky: assert property (exec_halt_o |-> s_halted)
    else $error("halt released or clock running");
  a_deliver_gated: assert property (|irq_deliver_o |-> core_clk_en_o && !exec_halt_o)
    else $error("interrupt delivered while clock stopped");
  a_stamp_steady: assert property (!$past(reset_i) && !$past(reset_i, 2)
    |-> time_stamp_o == $past(time_stamp_o) + 64'h1)
    else $error("time stamp skipped or stalled");
  a_irq_from_edge: assert property (therm_irq_o
    |-> $past(monitor_trip_i, 2) != $past(monitor_trip_i, 6))
    else $error("thermal irq without trip transition");
  a_irq_single: assert property (therm_irq_o |=> !therm_irq_o)
    else $error("thermal irq longer than one cycle");
  a_reset_state: assert property (disable iff (1'b0) reset_i
    |=> core_clk_en_o && !exec_halt_o && !therm_irq_o)
    else $error("outputs not at reset state");
endmodule

bind thermal_clock_throttle thermal_clock_throttle_checker #(
  .HOLD_CYCLES(HOLD_CYCLES)
) chk (.*);

// ==== bench/thermal_clock_throttle_tb_top.sv ====
// Self-checking bench for the thermal throttle
`timescale 1ns/1ps
`include "thermal_clock_throttle_regs.svh"
module thermal_clock_throttle_tb_top
  import thermal_clock_throttle_pkg::*;
;
  // Short hold so expiry fits the run
  localparam int HOLD = 200;
  logic       sys_clk_i, reset_i, cat_pin, mon_pin, wr, rd, ack, err, clk_en, halt, tirq, irq_on;
  logic [3:0] addr;
  logic [7:0] req, dlv, tvec, pend;
  logic [2:0] tmode;
  reg_word_t  wdata, rdata, ts;
  int         raised, taken, stray, errors, n_compared;

  thermal_clock_throttle #(
    .HOLD_CYCLES(HOLD)
  ) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .catastrophic_trip_i(cat_pin), .monitor_trip_i(mon_pin),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err),
    .core_clk_en_o(clk_en), .exec_halt_o(halt),
    .irq_req_i(req), .irq_deliver_o(dlv),
    .therm_irq_o(tirq), .therm_irq_vector_o(tvec), .therm_irq_mode_o(tmode),
    .time_stamp_o(ts)
  );
  core_irq_partner far (
    .sys_clk_i(sys_clk_i), .active_i(irq_on), .irq_req_o(req), .irq_deliver_i(dlv),
    .raised_o(raised), .taken_o(taken), .pending_o(pend), .stray_o(stray)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input reg_word_t exp, input reg_word_t got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic access(input logic w, input logic [3:0] a, input reg_word_t d,
                        output reg_word_t q, output logic e);
    @(negedge sys_clk_i);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    // Ack and data stand for the one cycle after the strobe edge
    @(negedge sys_clk_i);
    chk("ack", 64'h1, ack);
    q = rdata;
    e = err;
    wr = 1'b0;
    rd = 1'b0;
  endtask
  // Soft window: code n passes 2n of 16 cycles, reserved code 0 acts as 1
  function automatic reg_word_t soft_on_count(input logic [2:0] d);
    return (d == 3'h0) ? 64'd2 : 64'(d) * 64'd2;
  endfunction
  task automatic wr_reg(input logic [3:0] a, input reg_word_t d);
    reg_word_t q;
    logic e;
    access(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input reg_word_t x);
    reg_word_t q;
    logic e;
    access(1'b0, a, 64'h0, q, e);
    chk(what, x, q);
  endtask
  // Any 16 straight cycles span one whole gating window
  task automatic count_on(output reg_word_t n);
    n = 0;
    repeat (16) begin
      @(negedge sys_clk_i);
      n = n + clk_en;
    end
  endtask
  task automatic await(input bit for_halt);
    int k;
    for (k = 0; k < 12; k++) begin
      @(negedge sys_clk_i);
      if ((for_halt ? halt : tirq) === 1'b1) break;
    end
    if (k == 12) begin
      errors++;
      $display("CHECK FAILED %s expected 1 seen 0", for_halt ? "halt" : "thermal irq");
      give_verdict();
    end
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    reg_word_t  q, n;
    logic       e;
    logic [7:0] vec;
    logic [2:0] mode;
    logic [2:0] duty;
    errors = 0;
    n_compared = 0;
    {reset_i, cat_pin, mon_pin, wr, rd, irq_on} = 6'b100000;
    addr = 4'h0;
    wdata = 64'h0;
    void'($urandom(32'had33_e77a));
    repeat (6) @(negedge sys_clk_i);
    reset_i = 1'b0;
    rd_chk("misc enable", `IDX_MISC_ENABLE, 64'h0);
    rd_chk("state flags", `IDX_STATE_FLAGS, 64'h0);
    rd_chk("irq enables", `IDX_IRQ_ENABLES, 64'h0);
    rd_chk("vector entry", `IDX_THERMAL_VECTOR, 64'h1 << `BIT_VECTOR_MASK);
    access(1'b0, 4'h6 + 4'($urandom_range(9)), 64'h0, q, e);
    chk("unmapped data", 64'h0, q);
    chk("unmapped err", 64'h1, e);
    // Trip with monitor disabled must leave the clock alone
    mon_pin = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    count_on(n);
    chk("disabled duty", 64'd16, n);
    mon_pin = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    vec = 8'($urandom);
    mode = 3'($urandom_range(7));
    wr_reg(`IDX_THERMAL_VECTOR, {53'h0, mode, vec});
    wr_reg(`IDX_IRQ_ENABLES, 64'h3);
    wr_reg(`IDX_MISC_ENABLE, 64'h1 << `BIT_TM_ENABLE);
    irq_on = 1'b1;
    mon_pin = 1'b1;
    await(1'b0);
    chk("irq vector", vec, tvec);
    chk("irq mode", mode, tmode);
    repeat (4) @(negedge sys_clk_i);
    count_on(n);
    chk("thermal duty", 64'd8, n);
    rd_chk("flags hot", `IDX_STATE_FLAGS, 64'h3);
    duty = 3'($urandom_range(7));
    wr_reg(`IDX_SOFT_MODULATION, {59'h0, 1'b1, duty, 1'b0});
    rd_chk("soft modulation", `IDX_SOFT_MODULATION, {59'h0, 1'b1, duty, 1'b0});
    count_on(n);
    chk("override duty", 64'd8, n);
    mon_pin = 1'b0;
    await(1'b0);
    repeat (4) @(negedge sys_clk_i);
    count_on(n);
    chk("hold duty", 64'd8, n);
    rd_chk("flags cooled", `IDX_STATE_FLAGS, 64'h2);
    repeat (HOLD) @(negedge sys_clk_i);
    count_on(n);
    chk("soft duty", soft_on_count(duty), n);
    wr_reg(`IDX_STATE_FLAGS, 64'h0);
    rd_chk("log cleared", `IDX_STATE_FLAGS, 64'h0);
    // Masked vector entry: both edges of a trip must stay silent
    wr_reg(`IDX_THERMAL_VECTOR, (64'h1 << `BIT_VECTOR_MASK) | {56'h0, vec});
    n = 0;
    for (int i = 0; i < 16; i++) begin
      mon_pin = (i < 8);
      @(negedge sys_clk_i);
      n = n + tirq;
    end
    chk("masked irq", 64'h0, n);
    irq_on = 1'b0;
    repeat (40) @(negedge sys_clk_i);
    chk("irq taken", raised, taken);
    chk("irq pending", 64'h0, pend);
    chk("irq stray", 64'h0, stray);
    // Catastrophic trip outlives its pin and stops the clock but leaves the time stamp running
    cat_pin = 1'b1;
    await(1'b1);
    cat_pin = 1'b0;
    q = ts;
    count_on(n);
    chk("halted duty", 64'h0, n);
    chk("time stamp", q + 64'd16, ts);
    chk("halt held", 64'h1, halt);
    reset_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    reset_i = 1'b0;
    @(negedge sys_clk_i);
    chk("halt after reset", 64'h0, halt);
    rd_chk("vector after reset", `IDX_THERMAL_VECTOR, 64'h1 << `BIT_VECTOR_MASK);
    rd_chk("irq after reset", `IDX_IRQ_ENABLES, 64'h0);
    rd_chk("misc after reset", `IDX_MISC_ENABLE, 64'h0);
    give_verdict();
  end
endmodule

// ==== rtl/thermal_clock_throttle.sv ====
// Thermal throttle: trip handling, clock gating, status, thermal interrupt
`timescale 1ns/1ps
`include "thermal_clock_throttle_regs.svh"

module thermal_clock_throttle
  import thermal_clock_throttle_pkg::*;
#(
  parameter int HOLD_CYCLES = `HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // Sensor pins
  input  wire logic        catastrophic_trip_i,
  input  wire logic        monitor_trip_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [63:0] reg_wdata_i,
  output logic      [63:0] reg_rdata_o,
  output logic             reg_ack_o,
  output logic             reg_err_o,
  // Core clock gate and halt
  output logic             core_clk_en_o,
  output logic             exec_halt_o,
  // Core interrupt path
  input  wire logic [7:0]  irq_req_i,
  output logic      [7:0]  irq_deliver_o,
  // Thermal interrupt to the core
  output logic             therm_irq_o,
  output logic      [7:0]  therm_irq_vector_o,
  output logic      [2:0]  therm_irq_mode_o,
  // Free-running time stamp
  output logic      [63:0] time_stamp_o
);

  localparam logic [16:0] HOLD_LOAD = 17'(HOLD_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic        cat_meta;
  logic        cat_sync;
  logic        trip_meta;
  logic        trip_sync;
  logic        trip_prev;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cat_meta  <= 1'b0;
      cat_sync  <= 1'b0;
      trip_meta <= 1'b0;
      trip_sync <= 1'b0;
      trip_prev <= 1'b0;
    end else begin
      cat_meta  <= catastrophic_trip_i;
      cat_sync  <= cat_meta;
      trip_meta <= monitor_trip_i;
      trip_sync <= trip_meta;
      trip_prev <= trip_sync;
    end
  end

  // Edge of the sampled trip level
  wire trip_rise = trip_sync & ~trip_prev;
  wire trip_fall = ~trip_sync & trip_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic        tm_enable;
  logic        hot_log;
  logic        high_irq_en;
  logic        low_irq_en;
  logic        soft_enable;
  logic [2:0]  soft_duty;
  logic [7:0]  vector;
  logic [2:0]  mode;
  logic        vector_mask;
  logic [63:0] time_stamp;

  wire sel_misc   = (reg_addr_i == `IDX_MISC_ENABLE);
  wire sel_state  = (reg_addr_i == `IDX_STATE_FLAGS);
  wire sel_irq    = (reg_addr_i == `IDX_IRQ_ENABLES);
  wire sel_soft   = (reg_addr_i == `IDX_SOFT_MODULATION);
  wire sel_vector = (reg_addr_i == `IDX_THERMAL_VECTOR);
  wire sel_stamp  = (reg_addr_i == `IDX_TIME_STAMP);
  wire sel_any    = sel_misc | sel_state | sel_irq | sel_soft | sel_vector | sel_stamp;

  wire wr_misc   = reg_wr_i & sel_misc;
  wire wr_state  = reg_wr_i & sel_state;
  wire wr_irq    = reg_wr_i & sel_irq;
  wire wr_soft   = reg_wr_i & sel_soft;
  wire wr_vector = reg_wr_i & sel_vector;

  // Log bit: software clears by writing zero; a trip in that cycle wins
  wire log_clear   = wr_state & ~reg_wdata_i[`BIT_HOT_LOG];
  wire next_hot_log = trip_rise | (hot_log & ~log_clear);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tm_enable   <= 1'b0;
      hot_log     <= 1'b0;
      high_irq_en <= 1'b0;
      low_irq_en  <= 1'b0;
      soft_enable <= 1'b0;
      soft_duty   <= `RST_SOFT_DUTY;
      vector      <= `RST_VECTOR;
      mode        <= `RST_MODE;
      vector_mask <= `RST_VECTOR_MASK;
    end else begin
      hot_log <= next_hot_log;
      if (wr_misc) begin
        tm_enable <= reg_wdata_i[`BIT_TM_ENABLE];
      end
      if (wr_irq) begin
        high_irq_en <= reg_wdata_i[`BIT_HIGH_IRQ_EN];
        low_irq_en  <= reg_wdata_i[`BIT_LOW_IRQ_EN];
      end
      if (wr_soft) begin
        soft_enable <= reg_wdata_i[`BIT_SOFT_ENABLE];
        soft_duty   <= reg_wdata_i[`POS_SOFT_DUTY_HI:`POS_SOFT_DUTY_LO];
      end
      if (wr_vector) begin
        vector      <= reg_wdata_i[`POS_VECTOR_HI:`POS_VECTOR_LO];
        mode        <= reg_wdata_i[`POS_MODE_HI:`POS_MODE_LO];
        vector_mask <= reg_wdata_i[`BIT_VECTOR_MASK];
      end
    end
  end

  // Counts every edge; gating never touches it
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      time_stamp <= 64'h0000_0000_0000_0000;
    end else begin
      time_stamp <= time_stamp + 64'h0000_0000_0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Catastrophic halt

  logic halted;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      halted <= 1'b0;
    end else if (cat_sync) begin
      halted <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal hold timer

  logic [16:0] hold_cnt;
  wire         hold_busy = (hold_cnt != 17'h0_0000);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hold_cnt <= 17'h0_0000;
    end else if (trip_rise & tm_enable) begin
      hold_cnt <= HOLD_LOAD;
    end else if (hold_busy) begin
      hold_cnt <= hold_cnt - 17'h0_0001;
    end
  end

  // Throttling: sensor tripped, or still inside the minimum hold; hot only while tripped
  wire thermal_active = tm_enable & (trip_sync | hold_busy);
  wire hot_now        = thermal_active & trip_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Modulation state

  mod_state_t state;
  mod_state_t next_state;

  always_comb begin
    next_state = MOD_FULL;
    case (state)
      MOD_FULL: begin
        if (thermal_active) begin
          next_state = MOD_THERMAL;
        end else if (soft_enable) begin
          next_state = MOD_SOFT;
        end
      end
      MOD_THERMAL: begin
        if (thermal_active) begin
          next_state = MOD_THERMAL;
        end else if (soft_enable) begin
          next_state = MOD_SOFT;
        end
      end
      MOD_SOFT: begin
        if (thermal_active) begin
          next_state = MOD_THERMAL;
        end else if (soft_enable) begin
          next_state = MOD_SOFT;
        end
      end
      default: begin
        next_state = MOD_FULL;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= MOD_FULL;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop-clock window

  // Window of sixteen cycles; duty code n lets 2n of them through, code 0 counting as 1
  logic [4:0] phase;
  wire  [4:0] next_phase = (phase == `MOD_PERIOD - 5'h01) ? 5'h00 : phase + 5'h01;
  wire  [2:0] duty_code  = (soft_duty == 3'h0) ? `RST_SOFT_DUTY : soft_duty;
  wire  [4:0] soft_on    = {1'b0, duty_code, 1'b0};

  wire [4:0] on_cycles = (state == MOD_THERMAL) ? `THERMAL_ON_CYCLES :
                         (state == MOD_SOFT)    ? soft_on : `MOD_PERIOD;

  // Whole cycles are passed or held; the clock edge itself is never reshaped
  wire next_clk_en = ~halted & (next_phase < on_cycles);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      phase         <= 5'h00;
      core_clk_en_o <= 1'b1;
      exec_halt_o   <= 1'b0;
    end else begin
      phase         <= next_phase;
      core_clk_en_o <= next_clk_en;
      exec_halt_o   <= halted;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core interrupt holding

  // Deliver only on cycles the core is clocked
  logic [7:0] pending;
  wire        deliver_ok   = next_clk_en;
  wire  [7:0] deliver      = deliver_ok ? (pending | irq_req_i) : 8'h00;
  wire  [7:0] next_pending = (pending | irq_req_i) & ~deliver;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pending       <= 8'h00;
      irq_deliver_o <= 8'h00;
    end else begin
      pending       <= next_pending;
      irq_deliver_o <= deliver;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal interrupt

  wire therm_event = tm_enable & ((trip_rise & high_irq_en) |
                                  (trip_fall & low_irq_en));
  wire therm_fire  = therm_event & ~vector_mask;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      therm_irq_o        <= 1'b0;
      therm_irq_vector_o <= 8'h00;
      therm_irq_mode_o   <= 3'h0;
    end else begin
      therm_irq_o        <= therm_fire;
      therm_irq_vector_o <= vector;
      therm_irq_mode_o   <= mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read-back

  reg_word_t misc_word;
  reg_word_t state_word;
  reg_word_t irq_word;
  reg_word_t soft_word;
  reg_word_t vector_word;
  reg_word_t read_word;

  assign misc_word   = {60'h0, tm_enable, 3'h0};
  assign state_word  = {62'h0, hot_log, hot_now};
  assign irq_word    = {62'h0, low_irq_en, high_irq_en};
  assign soft_word   = {59'h0, soft_enable, soft_duty, 1'b0};
  assign vector_word = {47'h0, vector_mask, 5'h00, mode, vector};

  assign read_word = sel_misc   ? misc_word   :
                     sel_state  ? state_word  :
                     sel_irq    ? irq_word    :
                     sel_soft   ? soft_word   :
                     sel_vector ? vector_word :
                     sel_stamp  ? time_stamp  : 64'h0;

  wire access  = reg_rd_i | reg_wr_i;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o  <= 64'h0000_0000_0000_0000;
      reg_ack_o    <= 1'b0;
      reg_err_o    <= 1'b0;
      time_stamp_o <= 64'h0000_0000_0000_0000;
    end else begin
      reg_rdata_o  <= (reg_rd_i & sel_any) ? read_word : 64'h0;
      reg_ack_o    <= access;
      reg_err_o    <= access & ~sel_any;
      time_stamp_o <= time_stamp;
    end
  end

endmodule

// ==== rtl/thermal_clock_throttle_pkg.sv ====
// Types shared by the thermal throttle
package thermal_clock_throttle_pkg;
  typedef logic [63:0] reg_word_t;
  typedef enum logic [2:0] {
    MOD_FULL    = 3'b001,
    MOD_THERMAL = 3'b010,
    MOD_SOFT    = 3'b100
  } mod_state_t;
endpackage

// ==== rtl/thermal_clock_throttle_regs.svh ====
// Register indices, field positions, reset values and timing counts for the thermal throttle
`ifndef THERMAL_CLOCK_THROTTLE_REGS_SVH
`define THERMAL_CLOCK_THROTTLE_REGS_SVH

// Register indices on the register port
`define IDX_MISC_ENABLE      4'h0
`define IDX_STATE_FLAGS      4'h1
`define IDX_IRQ_ENABLES      4'h2
`define IDX_SOFT_MODULATION  4'h3
`define IDX_THERMAL_VECTOR   4'h4
`define IDX_TIME_STAMP       4'h5

// Field positions
`define BIT_TM_ENABLE        3
`define BIT_HOT_NOW          0
`define BIT_HOT_LOG          1
`define BIT_HIGH_IRQ_EN      0
`define BIT_LOW_IRQ_EN       1
`define BIT_SOFT_ENABLE      4
`define POS_SOFT_DUTY_LO     1
`define POS_SOFT_DUTY_HI     3
`define POS_VECTOR_LO        0
`define POS_VECTOR_HI        7
`define POS_MODE_LO          8
`define POS_MODE_HI          10
`define BIT_VECTOR_MASK      16

// Reset values
`define RST_SOFT_DUTY        3'h1
`define RST_VECTOR           8'h00
`define RST_MODE             3'h0
`define RST_VECTOR_MASK      1'b1

// Timing
`define CLK_MHZ              100
`define HOLD_TIME_US         1000
`define HOLD_CYCLES          (`HOLD_TIME_US * `CLK_MHZ)
`define MOD_PERIOD           5'h10
`define THERMAL_ON_CYCLES    5'h08

`endif
